// file: i2c_flags_pkg.sv
// constants and carrier types for the two-wire status flag logic
package i2c_flags_pkg;
   localparam int REG_ADDR_W = 4;
   localparam int DATA_W = 8;
   // register indices (word addresses on the plain port)
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_OWN_ADDR = 4'h2;
   localparam logic [3:0] ADDR_ROLE = 4'h3;
   localparam logic [3:0] ADDR_SHIFT_OUT = 4'h4;
   // status fields
   localparam int ST_MASTER_BIT = 7;
   localparam int ST_ARB_LOST_BIT = 6;
   localparam int ST_ADDR_MATCH_BIT = 4;
   localparam int ST_TX_DIR_BIT = 3;
   localparam int ST_ACK_SEEN_BIT = 2;
   // control fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_EXIT_BIT = 6;
   localparam int CTL_WAIT_REL_BIT = 5;
   // role register fields
   localparam int ROLE_MASTER_BIT = 0;
   localparam int ROLE_START_GEN_BIT = 1;
   localparam int ROLE_ARB_LOST_BIT = 2;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
   localparam logic [3:0] CLK_FIRST = 4'h1;
   localparam logic [3:0] CLK_EIGHTH = 4'h8;
   localparam logic [3:0] CLK_NINTH = 4'h9;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic startDet;
      logic stopDet;
   } bus_cond_t;
endpackage

// file: sync2.sv
// two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module sync2 (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // level
   input wire logic din,
   output logic dout
);
   logic meta_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // sync2

// file: i2c_status_flag_logic.sv
// status flags of the two-wire serial unit: address match, direction, ack seen, arbitration loss
// Operation
// - the arbitration-loss flag also clears when a single-bit read touches any other status bit.
// - address match is set at the eighth clock rise when the received address equals the own address.
// - address match clears on start, stop, exit write, enable falling, and reset.
// - with the direction flag at 0 the data pin is released.
// - with the direction flag at 1 the shift-out latch drives the data pin from the first ninth clock fall.
// - direction clears on stop, exit, enable falling, wait release, arbitration loss rising, and reset.
// - as master, direction sets on start generation and when 0 goes out as the first byte lsb.
// - as master, direction clears when 1 goes out as the first byte lsb.
// - as slave, direction sets when the first received byte lsb is 1.
// - as slave, direction clears on start detection and when the first byte lsb received is 0.
// - a wait release at the ninth clock with direction at 1 clears direction and floats the data pin.
// - ack seen sets when data is low at the ninth clock rise.
// - ack seen clears on stop, the next byte first clock rise, exit, enable falling, and reset.
// - exit sits at control bit 6 and enable at control bit 7.
// - status is eight bits: arbitration loss 6, address match 4, direction 3, ack 2.
// - arbitration loss sets on a lost arbitration and clears the master flag at once.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module i2c_status_flag_logic (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic regBitRd,
   input wire logic [2:0] regBitSel,
   output logic [7:0] regRdata,
   // start/stop detect from the neighbouring unit
   input wire logic startDet,
   input wire logic stopDet,
   // two-wire pins
   input wire logic serialClockIn,
   input wire logic serialDataIn,
   output logic serialDataOut,
   output logic serialDataOe
);
   i2c_flags_pkg::reg_req_t req;
   i2c_flags_pkg::bus_cond_t cond;
   logic sclSync, sdaSync, sclPrev_q;
   logic sclRise, sclFall;
   logic [3:0] clkCount_q;
   logic firstByte_q;
   logic [7:0] rxShift_q;
   logic [7:0] ctl_q, ownAddr_q, shiftOut_q;
   logic masterRole_q, master_q, arbLost_q, addrMatch_q, txDir_q, ackSeen_q;
   logic driveEn_q;
   logic enFall, exitWr, waitRelWr, arbLoseEv, startGenEv, arbLostClr;
   logic [7:0] statusVal;

   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
   assign cond = '{startDet: startDet, stopDet: stopDet};

   ////////////////////////////////////////////////////////////////////////
   sync2 uSclSync (
      .clock(clock),
      .rst_n(rst_n),
      .din(serialClockIn),
      .dout(sclSync)
   );
   sync2 uSdaSync (
      .clock(clock),
      .rst_n(rst_n),
      .din(serialDataIn),
      .dout(sdaSync)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sclPrev_q <= 1'b1;
      end else begin
         sclPrev_q <= sclSync;
      end
   end

   assign sclRise = sclSync & ~sclPrev_q;
   assign sclFall = ~sclSync & sclPrev_q;

   ////////////////////////////////////////////////////////////////////////
   // control events
   wire ctlWr = req.wr && (req.addr == i2c_flags_pkg::ADDR_CONTROL);
   wire roleWr = req.wr && (req.addr == i2c_flags_pkg::ADDR_ROLE);
   assign enFall = ctlWr && ctl_q[i2c_flags_pkg::CTL_ENABLE_BIT]
                   && !req.wdata[i2c_flags_pkg::CTL_ENABLE_BIT];
   assign exitWr = ctlWr && req.wdata[i2c_flags_pkg::CTL_EXIT_BIT];
   assign waitRelWr = ctlWr && req.wdata[i2c_flags_pkg::CTL_WAIT_REL_BIT];
   assign startGenEv = roleWr && req.wdata[i2c_flags_pkg::ROLE_START_GEN_BIT];
   assign arbLoseEv = roleWr && req.wdata[i2c_flags_pkg::ROLE_ARB_LOST_BIT];

   // exit and wait release are self-clearing strobes; enable and the rest hold
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= i2c_flags_pkg::CONTROL_RESET;
      end else if (ctlWr) begin
         ctl_q <= {req.wdata[7], 2'b00, req.wdata[4:0]};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ownAddr_q <= i2c_flags_pkg::OWN_ADDR_RESET;
         shiftOut_q <= 8'hFF;
         masterRole_q <= 1'b0;
      end else begin
         if (req.wr && req.addr == i2c_flags_pkg::ADDR_OWN_ADDR) begin
            ownAddr_q <= req.wdata;
         end
         if (req.wr && req.addr == i2c_flags_pkg::ADDR_SHIFT_OUT) begin
            shiftOut_q <= req.wdata;
         end
         if (roleWr) begin
            masterRole_q <= req.wdata[i2c_flags_pkg::ROLE_MASTER_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial clock counting per byte
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clkCount_q <= i2c_flags_pkg::BIT_COUNT_RESET;
         firstByte_q <= 1'b0;
         rxShift_q <= 8'h00;
      end else if (cond.startDet || cond.stopDet) begin
         clkCount_q <= i2c_flags_pkg::BIT_COUNT_RESET;
         firstByte_q <= cond.startDet;
         rxShift_q <= 8'h00;
      end else if (sclRise) begin
         rxShift_q <= {rxShift_q[6:0], sdaSync};
         if (clkCount_q == i2c_flags_pkg::CLK_NINTH) begin
            clkCount_q <= i2c_flags_pkg::CLK_FIRST;
            firstByte_q <= 1'b0;
         end else begin
            clkCount_q <= clkCount_q + 4'h1;
         end
      end
   end

   wire rise8 = sclRise && (clkCount_q == 4'h7) && !cond.startDet && !cond.stopDet;
   wire rise9 = sclRise && (clkCount_q == i2c_flags_pkg::CLK_EIGHTH) && !cond.startDet && !cond.stopDet;
   wire riseFirst = sclRise && (clkCount_q == i2c_flags_pkg::CLK_NINTH);
   wire fall9 = sclFall && (clkCount_q == i2c_flags_pkg::CLK_NINTH);
   wire [7:0] addrByte = {rxShift_q[6:0], sdaSync};
   wire dirBit = sdaSync;

   ////////////////////////////////////////////////////////////////////////
   // master flag and arbitration loss
   assign arbLostClr = (req.rd && req.addr == i2c_flags_pkg::ADDR_STATUS)
                       || (regBitRd && req.addr == i2c_flags_pkg::ADDR_STATUS);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         arbLost_q <= 1'b0;
      end else if (arbLoseEv) begin
         arbLost_q <= 1'b1;
      end else if (arbLostClr || enFall) begin
         arbLost_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         master_q <= 1'b0;
      end else if (arbLoseEv || cond.stopDet || exitWr || enFall) begin
         master_q <= 1'b0;
      end else if (startGenEv) begin
         master_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address match
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addrMatch_q <= 1'b0;
      end else if (rise8 && firstByte_q && addrByte[7:1] == ownAddr_q[7:1]) begin
         addrMatch_q <= 1'b1;
      end else if (cond.startDet || cond.stopDet || exitWr || enFall) begin
         addrMatch_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // direction flag
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txDir_q <= 1'b0;
      end else if (cond.stopDet || exitWr || enFall || arbLoseEv) begin
         txDir_q <= 1'b0;
      end else if (waitRelWr && txDir_q) begin
         txDir_q <= 1'b0;
      end else if (startGenEv) begin
         // generating a start makes us master, even when the role bit lands in the same write
         txDir_q <= 1'b1;
      end else if (!masterRole_q && cond.startDet) begin
         txDir_q <= 1'b0;
      end else if (rise8 && firstByte_q) begin
         // master sends 0 to write (transmit); slave sees 1 to be read from (transmit)
         txDir_q <= masterRole_q ? !dirBit : dirBit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ack seen
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ackSeen_q <= 1'b0;
      end else if (rise9 && !sdaSync) begin
         ackSeen_q <= 1'b1;
      end else if (cond.stopDet || riseFirst || exitWr || enFall) begin
         ackSeen_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data pin drive: armed at the ninth clock fall, dropped with direction
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         driveEn_q <= 1'b0;
      end else if (!txDir_q || (waitRelWr && txDir_q)) begin
         driveEn_q <= 1'b0;
      end else if (fall9) begin
         driveEn_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serialDataOut <= 1'b1;
         serialDataOe <= 1'b0;
      end else begin
         serialDataOut <= shiftOut_q[7];
         serialDataOe <= driveEn_q && txDir_q && !shiftOut_q[7];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read back; status register ignores writes
   always_comb begin
      statusVal = i2c_flags_pkg::STATUS_RESET;
      statusVal[i2c_flags_pkg::ST_MASTER_BIT] = master_q;
      statusVal[i2c_flags_pkg::ST_ARB_LOST_BIT] = arbLost_q;
      statusVal[i2c_flags_pkg::ST_ADDR_MATCH_BIT] = addrMatch_q;
      statusVal[i2c_flags_pkg::ST_TX_DIR_BIT] = txDir_q;
      statusVal[i2c_flags_pkg::ST_ACK_SEEN_BIT] = ackSeen_q;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regBitRd && req.addr == i2c_flags_pkg::ADDR_STATUS) begin
         regRdata <= {7'h00, statusVal[regBitSel]};
      end else if (req.rd) begin
         unique case (req.addr)
            i2c_flags_pkg::ADDR_STATUS: regRdata <= statusVal;
            i2c_flags_pkg::ADDR_CONTROL: regRdata <= ctl_q;
            i2c_flags_pkg::ADDR_OWN_ADDR: regRdata <= ownAddr_q;
            i2c_flags_pkg::ADDR_ROLE: regRdata <= {7'h00, masterRole_q};
            i2c_flags_pkg::ADDR_SHIFT_OUT: regRdata <= shiftOut_q;
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule // i2c_status_flag_logic

// file: i2c_status_flag_logic_monitor.sv
// assertions on the status flag logic ports
`timescale 1ns/1ps
module i2c_status_flag_logic_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic regBitRd,
   input wire logic [7:0] regRdata,
   // bus events and data pin
   input wire logic startDet,
   input wire logic stopDet,
   input wire logic serialDataOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire stRd = regRd && (regAddr == i2c_flags_pkg::ADDR_STATUS);
   wire ctlWr = regWr && (regAddr == i2c_flags_pkg::ADDR_CONTROL);
   wire arbWr = regWr && (regAddr == i2c_flags_pkg::ADDR_ROLE) && regWdata[2];
   property p_arb_clr; (stRd || regBitRd) ##1 stRd |=> !regRdata[6]; endproperty
   a_arb_clr: assert property (p_arb_clr) else $error("arb flag survived a status read");
   property p_match_clr; (startDet || stopDet) ##1 stRd |=> !regRdata[4]; endproperty
   a_match_clr: assert property (p_match_clr) else $error("match flag survived start or stop");
   property p_stop_dir; stopDet ##1 stRd |=> !regRdata[3]; endproperty
   a_stop_dir: assert property (p_stop_dir) else $error("direction survived stop");
   property p_stop_ack; stopDet ##1 stRd |=> !regRdata[2]; endproperty
   a_stop_ack: assert property (p_stop_ack) else $error("ack flag survived stop");
   property p_exit; ctlWr && regWdata[6] ##2 stRd |=> regRdata[4:2] == 3'b000; endproperty
   a_exit: assert property (p_exit) else $error("flags survived exit");
   property p_wrel; ctlWr && regWdata[5] ##2 stRd |=> !regRdata[3]; endproperty
   a_wrel: assert property (p_wrel) else $error("direction survived wait release");
   property p_arb_set; arbWr ##2 stRd |=> regRdata[6] && !regRdata[7] && !regRdata[3]; endproperty
   a_arb_set: assert property (p_arb_set) else $error("arb loss not flagged");
   property p_release; ctlWr && regWdata[6] |-> ##3 !serialDataOe; endproperty
   a_release: assert property (p_release) else $error("data pin still driven after exit");
endmodule // i2c_status_flag_logic_monitor
bind i2c_status_flag_logic i2c_status_flag_logic_monitor mon (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regBitRd(regBitRd), .regRdata(regRdata),
   .startDet(startDet), .stopDet(stopDet), .serialDataOe(serialDataOe));

// file: i2c_far_end.sv
// far-side two-wire master model driving clock and data lines
`timescale 1ns/1ps
module i2c_far_end (
   // bench clock, used only to hand control back on an edge
   input wire logic clock,
   // open-drain drivers, 1 = released
   output logic sclOut,
   output logic sdaOut
);
   initial begin
      sclOut = 1'b1;
      sdaOut = 1'b1;
   end
   task automatic startBus();
      sdaOut = 1'b0;
      #200 sclOut = 1'b0;
      // return on an edge so the caller's next nonblocking drive cannot race it
      @(posedge clock);
   endtask
   // clock parks low after the ninth pulse so no stray rise opens a byte
   task automatic sendByte(input logic [7:0] b, input logic ackLow);
      for (int i = 0; i < 9; i++) begin
         sdaOut = (i < 8) ? b[7 - i] : !ackLow;
         #200 sclOut = 1'b1;
         #200 sclOut = 1'b0;
      end
      sdaOut = 1'b1;
      @(posedge clock);
   endtask
   task automatic stopBus();
      sdaOut = 1'b0;
      #200 sclOut = 1'b1;
      #200 sdaOut = 1'b1;
      @(posedge clock);
   endtask
endmodule // i2c_far_end

// file: testbench.sv
// self-checking bench for the status flag logic
`timescale 1ns/1ps
module testbench;
   localparam int AL = i2c_flags_pkg::ST_ARB_LOST_BIT;
   localparam int AM = i2c_flags_pkg::ST_ADDR_MATCH_BIT;
   localparam int TD = i2c_flags_pkg::ST_TX_DIR_BIT;
   localparam int AK = i2c_flags_pkg::ST_ACK_SEEN_BIT;
   logic clock, rst_n, regWr, regRd, regBitRd, startDet, stopDet, serialDataOut, serialDataOe;
   logic [3:0] regAddr;
   logic [2:0] regBitSel;
   logic [7:0] regWdata, regRdata, exp, own;
   wire sclLine, sdaOut;
   // open drain: a pull-up unless someone pulls low
   wire sdaLine = sdaOut & ~serialDataOe;
   int nFail, cmpCount;
   i2c_far_end far (.clock(clock), .sclOut(sclLine), .sdaOut(sdaOut));
   i2c_status_flag_logic dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regBitRd(regBitRd), .regBitSel(regBitSel), .regRdata(regRdata),
      .startDet(startDet), .stopDet(stopDet), .serialClockIn(sclLine), .serialDataIn(sdaLine),
      .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
   always #25 clock = ~clock;
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmpCount++;
      if (s !== e) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rdReg(input logic [3:0] a, input logic [7:0] e, input string nm);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(nm, e, regRdata);
      @(posedge clock);
   endtask
   // pre: 0 plain, 1 bit read, 2 stop, 3 start, each directly before the byte read
   task automatic rdSt(input int pre);
      regAddr <= i2c_flags_pkg::ADDR_STATUS;
      if (pre != 0) begin
         regBitSel <= 3'($urandom);
         regBitRd <= (pre == 1);
         stopDet <= (pre == 2);
         startDet <= (pre == 3);
         @(posedge clock);
         {regBitRd, stopDet, startDet} <= 3'b000;
         if (pre == 1) exp[AL] = 1'b0;
         if (pre > 1) {exp[AM], exp[TD]} = 2'b00;
         if (pre == 2) exp[AK] = 1'b0;
      end
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk("status", exp & 8'h5C, regRdata & 8'h5C);
      exp[AL] = 1'b0;
      @(posedge clock);
   endtask
   task automatic frame(input logic [7:0] b, input logic ackLow);
      far.startBus();
      rdSt(3);
      far.sendByte(b, ackLow);
      exp[AM] = (b[7:1] == own[7:1]);
      exp[TD] = b[0];
      exp[AK] = ackLow;
      repeat (6) @(posedge clock);
   endtask
   task automatic endSim();
      $display("checks %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #500_000;
      nFail++;
      endSim();
   end
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      {regAddr, regWdata, regBitSel} = '0;
      {regWr, regRd, regBitRd, startDet, stopDet} = '0;
      exp = 8'h00;
      own = 8'($urandom(82450)) & 8'hFE;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rdSt(0);
      rdReg(4'hF, 8'h00, "unmapped");
      wr(i2c_flags_pkg::ADDR_OWN_ADDR, own);
      wr(i2c_flags_pkg::ADDR_SHIFT_OUT, 8'h00);
      wr(i2c_flags_pkg::ADDR_CONTROL, 8'h80);
      rdReg(i2c_flags_pkg::ADDR_CONTROL, 8'h80, "control");
      frame(own | 8'h01, 1'b1);
      rdSt(0);
      chk("dataOe", 8'h01, {7'h00, serialDataOe});
      wr(i2c_flags_pkg::ADDR_CONTROL, 8'hA0);
      exp[TD] = 1'b0;
      rdSt(0);
      chk("dataOe", 8'h00, {7'h00, serialDataOe});
      far.sendByte(8'($urandom), 1'b0);
      exp[AK] = 1'b0;
      repeat (6) @(posedge clock);
      rdSt(0);
      far.stopBus();
      rdSt(2);
      frame(own ^ 8'h02, 1'b1);
      rdSt(0);
      far.stopBus();
      rdSt(2);
      frame(own | 8'h01, 1'b0);
      wr(i2c_flags_pkg::ADDR_CONTROL, 8'hC0);
      {exp[AM], exp[TD], exp[AK]} = 3'b000;
      rdSt(0);
      far.stopBus();
      rdSt(2);
      wr(i2c_flags_pkg::ADDR_ROLE, 8'h03);
      exp[TD] = 1'b1;
      rdSt(0);
      wr(i2c_flags_pkg::ADDR_ROLE, 8'h05);
      {exp[AL], exp[TD]} = 2'b10;
      rdSt(0);
      wr(i2c_flags_pkg::ADDR_ROLE, 8'h04);
      exp[AL] = 1'b1;
      rdSt(1);
      wr(i2c_flags_pkg::ADDR_STATUS, 8'hFF);
      rdSt(0);
      endSim();
   end
endmodule // testbench
